// >>> hdl/eewg_pkg.sv
// Shared constants and types of the data EEPROM write guard
package eewg_pkg;
   // Data path widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register byte offsets on the register port
   localparam logic [7:0] OFF_DATA   = 8'h9A;
   localparam logic [7:0] OFF_ADDR   = 8'h9B;
   localparam logic [7:0] OFF_CTRL   = 8'h9C;
   localparam logic [7:0] OFF_UNLOCK = 8'h9D;
   localparam logic [7:0] OFF_STATUS = 8'h9E;

   // Field positions in eeprom_control and the event status register
   localparam int BIT_RD   = 0;
   localparam int BIT_WR   = 1;
   localparam int BIT_EN   = 2;
   localparam int BIT_ERR  = 3;
   localparam int BIT_DONE = 0;

   // Reset values
   localparam logic [3:0] CTRL_RESET   = 4'h0;
   localparam logic [7:0] RDDATA_RESET = 8'h00;
   localparam logic       FLAG_RESET   = 1'h0;

   // Unlock key bytes, in order
   localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

   // Timing: power-up delay in ms, clock in kHz, derived cycle count
   localparam int PUP_MS     = 72;
   localparam int CLK_KHZ    = 125000;
   localparam int PUP_CYCLES = PUP_MS * CLK_KHZ;

   // Cell programming time and unlock step spacing, in cycles
   localparam int WRITE_CYCLES = 1024;
   localparam int UNLOCK_GAP   = 4;

   // Unlock sequence tracker states
   typedef enum logic [2:0]
   {
      ARM_IDLE  = 3'b001,
      ARM_GOT55 = 3'b010,
      ARM_GOTAA = 3'b100
   } eewg_arm_e;
endpackage

// >>> hdl/eewg_mem_if.sv
// Link between the register logic and the EEPROM cell array
`timescale 1ns/1ps
`default_nettype none
interface eewg_mem_if;
   logic        start;
   logic        abort;
   logic [7:0]  wAddr;
   logic [7:0]  wData;
   logic [7:0]  rAddr;
   logic [7:0]  rData;
   logic        busy;
   logic        done;

   modport ctrl
   (
      output start,
      output abort,
      output wAddr,
      output wData,
      output rAddr,
      input  rData,
      input  busy,
      input  done
   );

   modport array
   (
      input  start,
      input  abort,
      input  wAddr,
      input  wData,
      input  rAddr,
      output rData,
      output busy,
      output done
   );
endinterface
`default_nettype wire

// >>> hdl/eewg_array.sv
// EEPROM cell array with timed byte programming
`timescale 1ns/1ps
`default_nettype none
module eewg_array
#(
   parameter int WRITE_CYCLES = eewg_pkg::WRITE_CYCLES
)
(
   input  wire logic mclk,
   input  wire logic reset_n,
   eewg_mem_if.array mem
);
   localparam int DEPTH = 1 << eewg_pkg::ADDR_W;
   localparam int CW    = $clog2(WRITE_CYCLES + 1);

   logic [7:0]    cells [DEPTH];
   logic [7:0]    latchAddr;
   logic [7:0]    latchData;
   logic [CW-1:0] count;
   logic          busy;
   wire           lastCycle;

   // Cells hold plain bytes; reads are combinational
   assign lastCycle = busy && (count == CW'(WRITE_CYCLES - 1));
   assign mem.busy  = busy;
   assign mem.done  = lastCycle && !mem.abort;
   assign mem.rData = cells[mem.rAddr];

   // Programming timer; an abort drops the byte
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busy  <= 1'h0;
         count <= '0;
      end
      else if (mem.abort || lastCycle)
      begin
         busy  <= 1'h0;
         count <= '0;
      end
      else if (mem.start)
      begin
         busy  <= 1'h1;
         count <= '0;
      end
      else if (busy)
         count <= count + CW'(1);
   end

   // Byte and address caught at start, cell written at completion
   always_ff @(posedge mclk)
   begin
      if (mem.start && !busy)
      begin
         latchAddr <= mem.wAddr;
         latchData <= mem.wData;
      end
      if (mem.done)
         cells[latchAddr] <= latchData;
   end
endmodule
`default_nettype wire

// >>> hdl/eewg_write_guard.sv
// Data EEPROM register block with write interlocks, top level
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Power-on clears the write enable latch.
// RULE2: No write starts during the power-up delay.
// RULE3: Write needs enable latch and fresh unlock.
// RULE4: Data stored and returned unscrambled always.
// RULE5: Unlock port has no storage, reads zero.
// RULE6: Control bits clear on any reset; warm reset keeps the error bit, or sets it during a write.
// RULE7: Data and address survive warm resets.
// RULE8: Control bits 7 to 4 read zero.
// RULE9: Software may verify by reading back.
// RULE10: Unlock is 55h, AAh, then write start.
// RULE11: Completion clears write bit, sets flag.
// RULE12: Read start loads data, then self-clears.
// RULE13: Warm reset during write sets error flag.
// RULE14: Dropping enable never aborts a running write.
module eewg_write_guard
#(
   parameter int PUP_CYCLES   = eewg_pkg::PUP_CYCLES,
   parameter int WRITE_CYCLES = eewg_pkg::WRITE_CYCLES,
   parameter int UNLOCK_GAP   = eewg_pkg::UNLOCK_GAP
)
(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       warmReset,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStb,
   input  wire logic       rdStb,
   output logic      [7:0] rdData,
   output logic            writeCompleteFlag,
   output logic            writeBusy
);
   localparam int PUP_W = $clog2(PUP_CYCLES + 1);
   localparam int GAP_W = $clog2(UNLOCK_GAP + 1);

   // Control state
   logic                enableLatch;
   logic                wrBit;
   logic                rdBit;
   logic                errorFlag;
   logic                completeFlag;
   eewg_pkg::eewg_arm_e armState;
   eewg_pkg::eewg_arm_e next_armState;
   logic [GAP_W-1:0]    gapCount;
   logic [GAP_W-1:0]    next_gapCount;
   logic [PUP_W-1:0]    pupCount;

   // Data path registers, no reset
   logic [7:0]          dataByte;
   logic [7:0]          addrByte;

   // Next values of control bits
   logic                next_enableLatch;
   logic                next_wrBit;
   logic                next_rdBit;
   logic                next_errorFlag;
   logic                next_completeFlag;

   // Decoded accesses
   wire                 selData;
   wire                 selAddr;
   wire                 selCtrl;
   wire                 selUnlock;
   wire                 selStatus;
   wire                 wrDataReg;
   wire                 wrAddrReg;
   wire                 wrCtrl;
   wire                 wrUnlock;
   wire                 wrStatus;
   wire                 anyAccess;
   wire                 unlock55;
   wire                 unlockAA;
   wire                 gapOver;
   wire                 pupRunning;
   wire                 wrSetReq;
   wire                 startWrite;
   wire                 rdSet;
   wire                 abortWrite;
   wire [7:0]           ctrlView;
   wire [7:0]           statusView;
   wire [7:0]           readMux;

   eewg_mem_if memLink ();

   // Address decode and write strobes per register
   assign selData   = (addr == eewg_pkg::OFF_DATA);
   assign selAddr   = (addr == eewg_pkg::OFF_ADDR);
   assign selCtrl   = (addr == eewg_pkg::OFF_CTRL);
   assign selUnlock = (addr == eewg_pkg::OFF_UNLOCK);
   assign selStatus = (addr == eewg_pkg::OFF_STATUS);
   assign wrDataReg = wrStb && selData;
   assign wrAddrReg = wrStb && selAddr;
   assign wrCtrl    = wrStb && selCtrl;
   assign wrUnlock  = wrStb && selUnlock;
   assign wrStatus  = wrStb && selStatus;
   assign anyAccess = wrStb || rdStb;

   // Unlock port writes only feed the sequence tracker
   assign unlock55 = wrUnlock && (wrData == eewg_pkg::UNLOCK_FIRST); // RULE5
   assign unlockAA = wrUnlock && (wrData == eewg_pkg::UNLOCK_SECOND);
   assign gapOver  = (gapCount >= GAP_W'(UNLOCK_GAP));

   // Power-up delay counts once after power-on only
   assign pupRunning = (pupCount != PUP_W'(PUP_CYCLES)); // RULE2

   // Write start interlock
   assign wrSetReq   = wrCtrl && wrData[eewg_pkg::BIT_WR];
   assign startWrite = wrSetReq && enableLatch // RULE3
                       && (armState == eewg_pkg::ARM_GOTAA) // RULE10
                       && !pupRunning // RULE2
                       && !wrBit && !warmReset;
   assign rdSet      = wrCtrl && wrData[eewg_pkg::BIT_RD] && !warmReset;
   assign abortWrite = warmReset && wrBit; // RULE13

   // Cell array requests
   assign memLink.start = startWrite;
   assign memLink.abort = abortWrite;
   assign memLink.wAddr = addrByte;
   assign memLink.wData = dataByte;
   assign memLink.rAddr = addrByte;

   // Unlock tracker: any stray access or a slow step breaks it
   always_comb
   begin
      next_armState = armState;
      case (armState)
         eewg_pkg::ARM_IDLE:
            if (unlock55)
               next_armState = eewg_pkg::ARM_GOT55;
         eewg_pkg::ARM_GOT55:
            if (unlockAA)
               next_armState = eewg_pkg::ARM_GOTAA; // RULE10
            else if (anyAccess || gapOver)
               next_armState = unlock55 ? eewg_pkg::ARM_GOT55
                                        : eewg_pkg::ARM_IDLE;
         eewg_pkg::ARM_GOTAA:
            if (anyAccess || gapOver)
               next_armState = unlock55 ? eewg_pkg::ARM_GOT55
                                        : eewg_pkg::ARM_IDLE;
         default:
            next_armState = eewg_pkg::ARM_IDLE;
      endcase
      if (warmReset)
         next_armState = eewg_pkg::ARM_IDLE;
   end

   // Step spacing counter restarts on every tracker step
   always_comb
   begin
      next_gapCount = '0;
      if ((next_armState == armState) &&
          (armState != eewg_pkg::ARM_IDLE) && !gapOver)
         next_gapCount = gapCount + GAP_W'(1);
   end

   // Next values of the control bits
   always_comb
   begin
      next_enableLatch = enableLatch;
      if (wrCtrl)
         next_enableLatch = wrData[eewg_pkg::BIT_EN];
      if (warmReset)
         next_enableLatch = 1'h0; // RULE6
      next_wrBit = wrBit;
      if (startWrite)
         next_wrBit = 1'h1;
      else if (memLink.done || warmReset)
         next_wrBit = 1'h0; // RULE11
      next_rdBit = rdSet; // RULE12
      next_errorFlag = errorFlag;
      if (wrCtrl)
         next_errorFlag = wrData[eewg_pkg::BIT_ERR];
      if (abortWrite)
         next_errorFlag = 1'h1; // RULE13
      next_completeFlag = completeFlag;
      if (wrStatus && !wrData[eewg_pkg::BIT_DONE])
         next_completeFlag = 1'h0;
      if (memLink.done)
         next_completeFlag = 1'h1; // RULE11
   end

   // Control flops; power-on clears them
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         enableLatch  <= eewg_pkg::CTRL_RESET[eewg_pkg::BIT_EN]; // RULE1
         wrBit        <= eewg_pkg::CTRL_RESET[eewg_pkg::BIT_WR];
         rdBit        <= eewg_pkg::CTRL_RESET[eewg_pkg::BIT_RD];
         errorFlag    <= eewg_pkg::CTRL_RESET[eewg_pkg::BIT_ERR];
         completeFlag <= eewg_pkg::FLAG_RESET;
         armState     <= eewg_pkg::ARM_IDLE;
         gapCount     <= '0;
      end
      else
      begin
         enableLatch  <= next_enableLatch;
         wrBit        <= next_wrBit; // RULE14
         rdBit        <= next_rdBit;
         errorFlag    <= next_errorFlag;
         completeFlag <= next_completeFlag;
         armState     <= next_armState;
         gapCount     <= next_gapCount;
      end
   end

   // Power-up delay counter, saturating
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         pupCount <= '0;
      else if (pupRunning)
         pupCount <= pupCount + PUP_W'(1);
   end

   // Data and address bytes keep their value over warm resets
   always_ff @(posedge mclk)
   begin
      if (rdBit)
         dataByte <= memLink.rData; // RULE12 RULE4
      else if (wrDataReg)
         dataByte <= wrData; // RULE7
      if (wrAddrReg)
         addrByte <= wrData;
   end

   // Read views; unused and unlock addresses read zero
   assign ctrlView   = {4'h0, errorFlag, enableLatch, wrBit, rdBit}; // RULE8
   assign statusView = {7'h00, completeFlag};
   assign readMux    = selData   ? dataByte   :
                       selAddr   ? addrByte   :
                       selCtrl   ? ctrlView   :
                       selStatus ? statusView : 8'h00; // RULE5

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         rdData <= eewg_pkg::RDDATA_RESET;
      else
         rdData <= rdStb ? readMux : eewg_pkg::RDDATA_RESET;
   end

   assign writeCompleteFlag = completeFlag;
   assign writeBusy         = wrBit;

   eewg_array
   #(
      .WRITE_CYCLES (WRITE_CYCLES)
   )
   cellArray
   (
      .mclk    (mclk),
      .reset_n (reset_n),
      .mem     (memLink.array)
   );

   // Checks on the interlocks
   enLatchPor_a: assert property ( // RULE1
      @(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> !enableLatch && !wrBit)
      else $error("enable latch not clear after power-on");

   pupBlock_a: assert property ( // RULE2
      @(posedge mclk) disable iff (!reset_n)
      pupRunning |=> !$rose(wrBit))
      else $error("write started during power-up delay");

   startGuard_a: assert property ( // RULE3
      @(posedge mclk) disable iff (!reset_n)
      $rose(wrBit) |-> $past(enableLatch)
         && ($past(armState) == eewg_pkg::ARM_GOTAA))
      else $error("write started without latch and unlock");

   unlockStep_a: assert property ( // RULE10
      @(posedge mclk) disable iff (!reset_n)
      (armState == eewg_pkg::ARM_GOT55) && unlockAA && !warmReset
      |=> armState == eewg_pkg::ARM_GOTAA)
      else $error("unlock tracker did not advance");

   unlockRead_a: assert property ( // RULE5
      @(posedge mclk) disable iff (!reset_n)
      rdStb && selUnlock |=> rdData == 8'h00)
      else $error("unlock port read nonzero");

   ctrlUpper_a: assert property ( // RULE8
      @(posedge mclk) disable iff (!reset_n)
      rdStb && selCtrl |=> rdData[7:4] == 4'h0)
      else $error("control upper bits read nonzero");

   warmClear_a: assert property ( // RULE6
      @(posedge mclk) disable iff (!reset_n)
      warmReset |=> !enableLatch && !wrBit && !rdBit)
      else $error("control bits not cleared by warm reset");

   warmKeep_a: assert property ( // RULE7
      @(posedge mclk) disable iff (!reset_n)
      warmReset && !wrDataReg && !wrAddrReg && !rdBit
      |=> $stable(dataByte) && $stable(addrByte))
      else $error("data or address lost over warm reset");

   warmError_a: assert property ( // RULE13
      @(posedge mclk) disable iff (!reset_n)
      warmReset && wrBit |=> errorFlag && !wrBit)
      else $error("aborted write did not raise error flag");

   doneFlag_a: assert property ( // RULE11
      @(posedge mclk) disable iff (!reset_n)
      memLink.done |=> !wrBit && completeFlag)
      else $error("write completion not reported");

   readLoad_a: assert property ( // RULE12
      @(posedge mclk) disable iff (!reset_n)
      rdSet ##1 !rdSet
      |-> rdBit ##1 !rdBit && dataByte == $past(memLink.rData))
      else $error("read start did not load data register");

   writeHold_a: assert property ( // RULE14
      @(posedge mclk) disable iff (!reset_n)
      wrBit && !enableLatch && !memLink.done && !warmReset |=> wrBit)
      else $error("running write lost without completion");

   unlockOnce_a: assert property ( // RULE10
      @(posedge mclk) disable iff (!reset_n)
      (armState == eewg_pkg::ARM_GOTAA) && anyAccess
      |=> armState != eewg_pkg::ARM_GOTAA)
      else $error("unlock served more than one access");

   unlockSlow_a: assert property ( // RULE10
      @(posedge mclk) disable iff (!reset_n)
      (armState != eewg_pkg::ARM_IDLE) && gapOver && !anyAccess
      |=> armState == eewg_pkg::ARM_IDLE)
      else $error("slow unlock step not dropped");

   flagSticky_a: assert property ( // RULE11
      @(posedge mclk) disable iff (!reset_n)
      completeFlag && !wrStatus
      |=> completeFlag)
      else $error("write complete flag lost without software");

   arrayStart_a: assert property ( // RULE3
      @(posedge mclk) disable iff (!reset_n)
      startWrite
      |=> wrBit && memLink.busy)
      else $error("accepted write did not start cell timer");
endmodule
`default_nettype wire

// >>> testbench/eewg_cpu_model.sv
// Behavioural CPU driving the register port of the write guard
`timescale 1ns/1ps
`default_nettype none
module eewg_cpu_model
(
   input  wire logic       mclk,
   input  wire logic [7:0] rdData,
   output logic      [7:0] addr,
   output logic      [7:0] wrData,
   output logic            wrStb,
   output logic            rdStb
);
   // Bus idle at time zero
   initial
   begin
      addr   = 8'h00;
      wrData = 8'h00;
      wrStb  = 1'b0;
      rdStb  = 1'b0;
   end

   // One-cycle write; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr   <= a;
      wrData <= d;
      wrStb  <= 1'b1;
      @(posedge mclk);
      wrStb  <= 1'b0;
      addr   <= ~a;
      wrData <= ~d;
   endtask

   // One-cycle read; data taken at the edge closing the answer cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      rdStb <= 1'b1;
      @(posedge mclk);
      rdStb <= 1'b0;
      addr  <= ~a;
      @(posedge mclk);
      d = rdData;
   endtask
endmodule
`default_nettype wire

// >>> testbench/eewg_write_guard_tb_top.sv
// Self-checking bench of the data EEPROM write guard
`timescale 1ns/1ps
`default_nettype none
module eewg_write_guard_tb_top;
   localparam int PUP  = 20;
   localparam int WCYC = 8;
   logic        mclk;
   logic        reset_n;
   logic        warmReset;
   logic [7:0]  addr;
   logic [7:0]  wrData;
   logic [7:0]  rdData;
   logic        wrStb;
   logic        rdStb;
   logic        writeCompleteFlag;
   logic        writeBusy;
   int          miscompares;
   int          check_count;
   int          cycles;
   int          mem [256];
   int          dataReg;
   int          addrReg;
   int          pend [$];
   int          rq;
   logic [31:0] seed;
   logic [7:0]  got;
   logic [7:0]  ra;
   logic [7:0]  rv;

   eewg_write_guard #(.PUP_CYCLES(PUP), .WRITE_CYCLES(WCYC)) dut
   (
      .mclk              (mclk),
      .reset_n           (reset_n),
      .warmReset         (warmReset),
      .addr              (addr),
      .wrData            (wrData),
      .wrStb             (wrStb),
      .rdStb             (rdStb),
      .rdData            (rdData),
      .writeCompleteFlag (writeCompleteFlag),
      .writeBusy         (writeBusy)
   );

   eewg_cpu_model cpu
   (
      .mclk   (mclk),
      .rdData (rdData),
      .addr   (addr),
      .wrData (wrData),
      .wrStb  (wrStb),
      .rdStb  (rdStb)
   );

   // Clock at 125 MHz
   initial
      mclk = 1'b0;
   always #4 mclk = ~mclk;

   // Hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         miscompares++;
         stop_test();
      end
   end

   function automatic logic [7:0] nextRand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                      input string n);
      cpu.rd(a, got);
      chk(n, e, got);
   endtask

   // Full programming sequence for one byte
   task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
      cpu.wr(eewg_pkg::OFF_DATA, d);
      cpu.wr(eewg_pkg::OFF_ADDR, a);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h04);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'h55);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'hAA);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h06);
      #1;
      dataReg = d;
      addrReg = a;
      pend.push_back(int'(a) * 256 + int'(d));
   endtask

   // Read one cell into the data register and fetch it
   task automatic ee_read(input logic [7:0] a);
      cpu.wr(eewg_pkg::OFF_ADDR, a);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h01);
      cpu.rd(eewg_pkg::OFF_DATA, got);
      dataReg = mem[a];
      addrReg = a;
   endtask

   task automatic wait_done;
      int n;
      n = 0;
      while (writeBusy !== 1'b0 && n < 100)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      reset_n     = 1'b0;
      warmReset   = 1'b0;
      seed        = 32'd18877;
      miscompares = 0;
      check_count = 0;
      cycles      = 0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rdc(eewg_pkg::OFF_CTRL, 8'h00, "ctrl at power-on");
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h04);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'h55);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'hAA);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h06);
      #1;
      chk("busy in delay", 8'h00, {7'h0, writeBusy});
      repeat (PUP) @(posedge mclk);
      rdc(eewg_pkg::OFF_CTRL, 8'h04, "ctrl enable only");
      rdc(eewg_pkg::OFF_UNLOCK, 8'h00, "unlock port");
      rdc(8'h10, 8'h00, "unmapped");
      rdc(eewg_pkg::OFF_STATUS, 8'h00, "status idle");
      // Enable latch alone
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h06);
      #1;
      chk("busy no unlock", 8'h00, {7'h0, writeBusy});
      // Unlock alone, latch clear
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h00);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'h55);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'hAA);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h06);
      #1;
      chk("busy no enable", 8'h00, {7'h0, writeBusy});
      // Keys in the wrong order
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h04);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'hAA);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'h55);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h06);
      #1;
      chk("busy bad order", 8'h00, {7'h0, writeBusy});
      // Unlock steps too far apart, then split by a stray read
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'h55);
      repeat (6) @(posedge mclk);
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'hAA);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h06);
      #1;
      chk("busy slow keys", 8'h00, {7'h0, writeBusy});
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'h55);
      rdc(eewg_pkg::OFF_CTRL, 8'h04, "ctrl mid unlock");
      cpu.wr(eewg_pkg::OFF_UNLOCK, 8'hAA);
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h06);
      #1;
      chk("busy stray access", 8'h00, {7'h0, writeBusy});
      // Random bytes written, enable dropped mid-write, verified
      for (int k = 0; k < 3; k++)
      begin
         ra = nextRand();
         rv = nextRand();
         ee_write(ra, rv);
         chk("busy started", 8'h01, {7'h0, writeBusy});
         cpu.wr(eewg_pkg::OFF_CTRL, 8'h00);
         wait_done();
         rq = pend.pop_front();
         mem[rq / 256] = rq % 256;
         chk("busy end", 8'h00, {7'h0, writeBusy});
         chk("done flag", 8'h01, {7'h0, writeCompleteFlag});
         rdc(eewg_pkg::OFF_STATUS, 8'h01, "status done");
         cpu.wr(eewg_pkg::OFF_STATUS, 8'h01);
         rdc(eewg_pkg::OFF_STATUS, 8'h01, "status kept");
         rdc(eewg_pkg::OFF_CTRL, 8'h00, "ctrl after write");
         ee_read(ra);
         chk("read back", 8'(mem[ra]), got);
         rdc(eewg_pkg::OFF_CTRL, 8'h00, "read bit clear");
         cpu.wr(eewg_pkg::OFF_STATUS, 8'h00);
         #1;
         chk("flag cleared", 8'h00, {7'h0, writeCompleteFlag});
      end
      // Warm reset in mid-write
      ra = nextRand();
      rv = nextRand();
      ee_write(ra, rv);
      @(posedge mclk);
      warmReset <= 1'b1;
      @(posedge mclk);
      warmReset <= 1'b0;
      pend.delete();
      #1;
      chk("busy aborted", 8'h00, {7'h0, writeBusy});
      rdc(eewg_pkg::OFF_CTRL, 8'h08, "ctrl error");
      rdc(eewg_pkg::OFF_DATA, 8'(dataReg), "data kept");
      rdc(eewg_pkg::OFF_ADDR, 8'(addrReg), "addr kept");
      rdc(eewg_pkg::OFF_STATUS, 8'h00, "no completion");
      cpu.wr(eewg_pkg::OFF_CTRL, 8'h00);
      rdc(eewg_pkg::OFF_CTRL, 8'h00, "error cleared");
      stop_test();
   end
endmodule
`default_nettype wire
